//--- hw/iec_pkg.sv
/*
  Constants, register map and carrier types of the incremental encoder
  counter. Assumes a 32-bit APB master and a 20 MHz system clock.
*/
package iec_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] IEC_OFF_CTRL   = 12'h000;
  localparam logic [11:0] IEC_OFF_KEY    = 12'h004;
  localparam logic [11:0] IEC_OFF_SUPPLY = 12'h008;
  localparam logic [11:0] IEC_OFF_LOWER  = 12'h00c;
  localparam logic [11:0] IEC_OFF_UPPER  = 12'h010;
  localparam logic [11:0] IEC_OFF_PRESET = 12'h014;
  localparam logic [11:0] IEC_OFF_COUNT  = 12'h018;
  localparam logic [11:0] IEC_OFF_STATUS = 12'h01c;

  // ==========================================================
  // Control field positions
  localparam int IEC_CTRL_MODE_LSB = 0;
  localparam int IEC_CTRL_EVAL_LSB = 4;
  localparam int IEC_CTRL_INV      = 8;
  localparam int IEC_CTRL_CERR     = 9;
  localparam int IEC_CTRL_COMPACT  = 10;

  // Status field positions
  localparam int IEC_ST_UNDER = 0;
  localparam int IEC_ST_OVER  = 1;
  localparam int IEC_ST_RANGE = 2;
  localparam int IEC_ST_B     = 3;
  localparam int IEC_ST_CFLT  = 4;

  // ==========================================================
  // Values
  localparam logic [31:0] IEC_UNLOCK_KEY = 32'h72657375;
  localparam logic [31:0] IEC_MAX32      = 32'hffffffff;
  localparam logic [31:0] IEC_MAX16      = 32'h0000ffff;
  localparam logic [31:0] IEC_LOWER_RST  = 32'h00000000;

  typedef enum logic [1:0] {
    IEC_EVAL_1X = 2'b00,
    IEC_EVAL_2X = 2'b01,
    IEC_EVAL_4X = 2'b10
  } iec_eval_t;

  typedef enum logic [1:0] {
    IEC_SUP_5V  = 2'b00,
    IEC_SUP_12V = 2'b01,
    IEC_SUP_24V = 2'b10
  } iec_sup_t;

  typedef enum logic [2:0] {
    IEC_M_QD_DIFF = 3'b000,
    IEC_M_PD_DIFF = 3'b001,
    IEC_M_QD_TTL  = 3'b010,
    IEC_M_PD_TTL  = 3'b011,
    IEC_M_QD_OC   = 3'b100,
    IEC_M_PD_OC   = 3'b101
  } iec_mode_t;

  typedef enum logic [1:0] {
    IEC_ST_IDLE   = 2'b00,
    IEC_ST_ACCESS = 2'b01
  } iec_bus_st_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } iec_tracks_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } iec_apb_req_t;

endpackage

//--- hw/iec_counter.sv
/*
  Incremental encoder position counter with an APB register slave.
  Assumes track inputs are asynchronous pins, the C fault level comes
  from the line receiver, and the APB master runs on i_mclk.
*/
// Operation
// - Mode selects quadrature or pulse/direction input
// - Zero-pulse fault detection off after reset
// - Enabled zero-pulse fault drives fault indicator
// - Supply selection 5/12/24 V, default 5 V
// - Supply writes need unlock key loaded
// - Count edges per 1-, 2-, 4-fold evaluation
// - Evaluation defaults to 4-fold
// - Default limits wrap from maximum to zero
// - Depth 32 bits standard, 16 compact
// - Below lower limit continue at upper limit
// - Limits writable only after unlock key
// - Reject limit unless lower below upper
// - Out-of-range preset loads and flags
// - New limits excluding count set flag
// - Underflow flag set, cleared below two thirds
// - Overflow flag set, cleared above one third
// - A leading B counts forward
// - Inversion swaps quadrature direction
// - Pulse mode: B low up, high down
// - Inversion swaps pulse direction too
// - Track B level shown in status
`timescale 1ns/1ns
module iec_counter
  import iec_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire iec_tracks_t i_trk,
  input  wire logic        i_c_fault,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [1:0]  o_supply_sel,
  output logic             o_c_fault_led
);

  // ==========================================================
  // Functions
  function automatic logic [31:0] iec_third(input logic [31:0] lo,
                                            input logic [31:0] hi,
                                            input logic        two);
    logic [33:0] span;
    span = {2'b00, hi - lo};
    if (two) begin
      iec_third = lo + 32'((span * 34'd2) / 34'd3);
    end else begin
      iec_third = lo + 32'(span / 34'd3);
    end
  endfunction

  function automatic logic iec_outside(input logic [31:0] v,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
    iec_outside = (v < lo) || (v > hi);
  endfunction

  // ==========================================================
  // Synchronisers
  iec_tracks_t sync1_q;
  iec_tracks_t sync2_q;
  iec_tracks_t prev_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= i_trk;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ==========================================================
  // Registers
  logic [2:0]  mode_q;
  iec_eval_t   eval_q;
  logic        inv_q;
  logic        cerr_en_q;
  logic        compact_q;
  logic [31:0] key_q;
  iec_sup_t    sup_q;
  logic [31:0] lower_q;
  logic [31:0] upper_q;
  logic        upper_set_q;
  logic [31:0] count_q;
  logic        under_q;
  logic        over_q;
  logic        range_q;
  logic        led_q;

  logic        wr_acc;
  logic        unlocked;
  logic        preset_wr;
  logic        lim_wr;
  logic [31:0] maxd;
  logic [31:0] eff_upper;
  logic [31:0] new_lower;
  logic [31:0] new_upper;

  assign wr_acc    = i_psel && i_penable && i_pwrite;
  assign unlocked  = (key_q == IEC_UNLOCK_KEY);
  assign maxd      = compact_q ? IEC_MAX16 : IEC_MAX32;
  assign eff_upper = upper_set_q ? upper_q : maxd;
  assign preset_wr = wr_acc && (i_paddr == IEC_OFF_PRESET);
  assign new_lower = (i_paddr == IEC_OFF_LOWER) ? i_pwdata : lower_q;
  assign new_upper = (i_paddr == IEC_OFF_UPPER) ? i_pwdata : eff_upper;
  assign lim_wr    = wr_acc && unlocked && (new_lower < new_upper) &&
                     ((i_paddr == IEC_OFF_LOWER) ||
                      (i_paddr == IEC_OFF_UPPER));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_q    <= IEC_M_QD_DIFF;
      eval_q    <= IEC_EVAL_4X;
      inv_q     <= 1'b0;
      cerr_en_q <= 1'b0;
      compact_q <= 1'b0;
    end else if (wr_acc && (i_paddr == IEC_OFF_CTRL)) begin
      mode_q    <= i_pwdata[IEC_CTRL_MODE_LSB +: 3];
      eval_q    <= iec_eval_t'(i_pwdata[IEC_CTRL_EVAL_LSB +: 2]);
      inv_q     <= i_pwdata[IEC_CTRL_INV];
      cerr_en_q <= i_pwdata[IEC_CTRL_CERR];
      compact_q <= i_pwdata[IEC_CTRL_COMPACT];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      key_q <= '0;
    end else if (wr_acc && (i_paddr == IEC_OFF_KEY)) begin
      key_q <= i_pwdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sup_q <= IEC_SUP_5V;
    end else if (wr_acc && unlocked && (i_paddr == IEC_OFF_SUPPLY) &&
                 (i_pwdata[1:0] != 2'b11)) begin
      sup_q <= iec_sup_t'(i_pwdata[1:0]);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lower_q     <= IEC_LOWER_RST;
      upper_q     <= IEC_MAX32;
      upper_set_q <= 1'b0;
    end else if (lim_wr) begin
      lower_q <= new_lower;
      upper_q <= new_upper;
      if (i_paddr == IEC_OFF_UPPER) begin
        upper_set_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Edge decode and direction
  logic a_rise;
  logic a_edge;
  logic b_edge;
  logic quad;
  logic step;
  logic fwd;
  logic quad_fwd;

  assign a_rise = sync2_q.a && !prev_q.a;
  assign a_edge = sync2_q.a ^ prev_q.a;
  assign b_edge = sync2_q.b ^ prev_q.b;
  assign quad   = !mode_q[0];
  // A leads B: on an A edge the new A differs from B
  assign quad_fwd = a_edge ? (sync2_q.a ^ sync2_q.b)
                           : !(sync2_q.a ^ sync2_q.b);

  always_comb begin
    case (eval_q)
      IEC_EVAL_1X: step = a_rise;
      IEC_EVAL_2X: step = a_edge;
      IEC_EVAL_4X: step = quad ? (a_edge || b_edge) : a_edge;
      default:     step = 1'b0;
    endcase
    if (quad) begin
      fwd = quad_fwd ^ inv_q;
    end else begin
      fwd = !sync2_q.b ^ inv_q;
    end
  end

  // ==========================================================
  // Counter and flags
  logic        wrap_up;
  logic        wrap_dn;
  logic [31:0] count_d;

  assign wrap_up = step && fwd && (count_q == eff_upper);
  assign wrap_dn = step && !fwd && (count_q == lower_q);

  always_comb begin
    count_d = count_q;
    if (preset_wr) begin
      count_d = i_pwdata & maxd;
    end else if (wrap_up) begin
      count_d = lower_q;
    end else if (wrap_dn) begin
      count_d = eff_upper;
    end else if (step && fwd) begin
      count_d = (count_q + 32'h00000001) & maxd;
    end else if (step) begin
      count_d = (count_q - 32'h00000001) & maxd;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      under_q <= 1'b0;
    end else if (wrap_dn) begin
      under_q <= 1'b1;
    end else if (count_q < iec_third(lower_q, eff_upper, 1'b1)) begin
      under_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      over_q <= 1'b0;
    end else if (wrap_up) begin
      over_q <= 1'b1;
    end else if (count_q > iec_third(lower_q, eff_upper, 1'b0)) begin
      over_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      range_q <= 1'b0;
    end else begin
      range_q <= iec_outside(count_q, lower_q, eff_upper);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      led_q <= 1'b0;
    end else begin
      led_q <= cerr_en_q && i_c_fault;
    end
  end

  // ==========================================================
  // APB read path, no wait states
  iec_bus_st_t bus_q;
  logic [31:0] rd_d;
  logic        hit;

  always_comb begin
    rd_d = '0;
    hit  = 1'b1;
    case (i_paddr)
      IEC_OFF_CTRL:   rd_d = {21'h000000, compact_q, cerr_en_q, inv_q,
                              2'b00, eval_q, 1'b0, mode_q};
      IEC_OFF_KEY:    rd_d = {31'h00000000, unlocked};
      IEC_OFF_SUPPLY: rd_d = {30'h00000000, sup_q};
      IEC_OFF_LOWER:  rd_d = lower_q;
      IEC_OFF_UPPER:  rd_d = eff_upper;
      IEC_OFF_PRESET: rd_d = '0;
      IEC_OFF_COUNT:  rd_d = count_q;
      IEC_OFF_STATUS: rd_d = {27'h0000000, led_q, sync2_q.b, range_q,
                              over_q, under_q};
      default:        hit  = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bus_q     <= IEC_ST_IDLE;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      case (bus_q)
        IEC_ST_IDLE: begin
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
          if (i_psel && !i_penable) begin
            bus_q     <= IEC_ST_ACCESS;
            o_pready  <= 1'b1;
            o_pslverr <= !hit;
            o_prdata  <= i_pwrite ? 32'h00000000 : rd_d;
          end
        end
        IEC_ST_ACCESS: begin
          bus_q     <= IEC_ST_IDLE;
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default: bus_q <= IEC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_supply_sel  <= IEC_SUP_5V;
      o_c_fault_led <= 1'b0;
    end else begin
      o_supply_sel  <= sup_q;
      o_c_fault_led <= led_q;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_preset_out;
    preset_wr && iec_outside(i_pwdata & maxd, lower_q, eff_upper) && !lim_wr;
  endsequence

  a_eval_reset: assert property (@(posedge i_mclk)
    $fell(i_rst) |-> eval_q == IEC_EVAL_4X)
    else $error("Evaluation not 4-fold after reset");
  a_supply_lock: assert property (@(posedge i_mclk) disable iff (i_rst)
    !unlocked |=> $stable(sup_q))
    else $error("Supply changed while locked");
  a_limit_order: assert property (@(posedge i_mclk) disable iff (i_rst)
    $changed(lower_q) |-> lower_q < upper_q)
    else $error("Lower limit not below upper");
  a_wrap_upper: assert property (@(posedge i_mclk) disable iff (i_rst)
    wrap_up && !preset_wr |=> count_q == $past(lower_q) && over_q)
    else $error("Upward wrap wrong");
  a_wrap_lower: assert property (@(posedge i_mclk) disable iff (i_rst)
    wrap_dn && !preset_wr |=> count_q == $past(eff_upper) && under_q)
    else $error("Downward wrap wrong");
  a_cerr_led: assert property (@(posedge i_mclk) disable iff (i_rst)
    !cerr_en_q |-> ##2 !o_c_fault_led)
    else $error("C fault shown while disabled");
  a_preset_range: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_preset_out ##1 !step |=> range_q)
    else $error("Out-of-range preset not flagged");
  a_under_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    !wrap_dn && count_q < iec_third(lower_q, eff_upper, 1'b1)
      |=> !under_q)
    else $error("Underflow flag not cleared");
  a_track_sync: assert property (@(posedge i_mclk) disable iff (i_rst)
    !$past(i_rst) && !$past(i_rst, 2)
      |-> sync2_q == $past(i_trk, 2))
    else $error("Track synchroniser depth wrong");
  a_pulse_dir: assert property (@(posedge i_mclk) disable iff (i_rst)
    step && !quad && !preset_wr && !wrap_up && !wrap_dn && !inv_q
      && !sync2_q.b |=> count_q == (($past(count_q) + 1) & maxd))
    else $error("Pulse mode direction wrong");
  a_b_status: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_psel && !i_penable && !i_pwrite && i_paddr == IEC_OFF_STATUS
      |=> o_prdata[IEC_ST_B] == $past(sync2_q.b))
    else $error("B status wrong");

endmodule

//--- dv/iec_enc_model.sv
/*
  Behavioural encoder or pulse generator driving tracks A and B, with C held low.
  Assumes the bench calls its tasks from one process at a clock edge.
*/
`timescale 1ns/1ns
module iec_enc_model
  import iec_pkg::*;
(
  input  wire logic   i_clk,
  output iec_tracks_t o_trk
);
  // ==================
  // Track drive
  int ph = 0;
  initial o_trk = '0;
  task automatic put(input logic a, input logic b);
    @(posedge i_clk);
    o_trk.a <= a;
    o_trk.b <= b;
    repeat (4) @(posedge i_clk);
  endtask
  // Quarter-period step, A leads B going forward
  task automatic quad(input int d);
    ph = (ph + (d > 0 ? 1 : 3)) % 4;
    put(ph == 1 || ph == 2, ph >= 2);
  endtask
  // One pulse on A with the direction level held on B
  task automatic pulse(input logic b);
    put(1'b0, b);
    put(1'b1, b);
    put(1'b0, b);
  endtask
endmodule

//--- dv/tb.sv
/*
  Self-checking bench: APB master, reference model, encoder partner.
  Assumes one 20 MHz clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module tb
  import iec_pkg::*;
;
  logic        i_mclk, i_rst, i_c_fault, psel, pen, pwr, pready, pslverr;
  logic        led, er, inv;
  logic [1:0]  sup;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  iec_tracks_t trk;
  int          failures, compares, seed, ev, und, ovf, n;
  longint      cnt, lo, hi;

  iec_counter uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_trk(trk),
    .i_c_fault(i_c_fault), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_supply_sel(sup), .o_c_fault_led(led));
  iec_enc_model enc (.i_clk(i_mclk), .o_trk(trk));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // ==================
  // Checking and bus tasks
  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0);
    chk(rv & m, e & m);
  endtask

  // ==================
  // Reference model
  task automatic mstep(input int d);
    if (d > 0 && cnt == hi) begin
      cnt = lo;
      ovf = 2;
    end else if (d > 0) begin
      cnt++;
    end else if (cnt == lo) begin
      cnt = hi;
      und = 2;
    end else begin
      cnt--;
    end
    mclr();
  endtask
  // Flags clear on the level of the count, presets included
  task automatic mclr();
    if (ovf == 1 && cnt > lo + (hi - lo) / 3) ovf = 0;
    if (und == 1 && cnt < lo + 2 * (hi - lo) / 3) und = 0;
    ovf = ovf != 0;
    und = und != 0;
  endtask
  function automatic logic [31:0] st();
    return {28'h0, trk.b, cnt < lo || cnt > hi, ovf[0], und[0]};
  endfunction
  task automatic q(input int d, input int k);
    int p;
    logic ao;
    repeat (k) begin
      p = enc.ph;
      ao = p == 1 || p == 2;
      enc.quad(d);
      p = enc.ph;
      if (ev == 2 || (ao != (p == 1 || p == 2) && (ev == 1 || !ao)))
        mstep(inv ? -d : d);
    end
  endtask
  task automatic pl(input logic b, input int k);
    repeat (k) begin
      enc.pulse(b);
      mstep((b ^ inv) ? -1 : 1);
      if (ev != 0) mstep((b ^ inv) ? -1 : 1);
    end
  endtask
  task automatic pre(input logic [31:0] v);
    wr(IEC_OFF_PRESET, v);
    cnt = v;
    mclr();
  endtask

  // ==================
  // Scenarios
  initial begin
    i_rst = 1'b1;
    {i_c_fault, psel, pen, pwr, paddr, pwdata} = '0;
    {failures, compares, und, ovf, inv} = '0;
    seed = 32'h2b605242;
    ev = 2;
    cnt = 0;
    lo = 0;
    hi = 32'hffffffff;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd(IEC_OFF_CTRL, 32'h20);
    rd(IEC_OFF_SUPPLY, 32'h0);
    wr(IEC_OFF_SUPPLY, 32'h1);
    rd(IEC_OFF_SUPPLY, 32'h0);
    wr(IEC_OFF_KEY, IEC_UNLOCK_KEY);
    wr(IEC_OFF_SUPPLY, 32'h2);
    wr(IEC_OFF_SUPPLY, 32'h3);
    rd(IEC_OFF_SUPPLY, 32'h2);
    chk({30'h0, sup}, 32'h2);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    n = 1 + ($unsigned($random(seed)) % 8);
    q(1, n);
    rd(IEC_OFF_COUNT, 32'(cnt));
    q(-1, n + 1);
    rd(IEC_OFF_COUNT, 32'(cnt));
    rd(IEC_OFF_STATUS, st());
    q(1, 1);
    rd(IEC_OFF_STATUS, st());
    wr(IEC_OFF_CTRL, 32'h120);
    inv = 1'b1;
    q(1, 3);
    rd(IEC_OFF_COUNT, 32'(cnt));
    inv = 1'b0;
    for (int e = 0; e < 3; e++) begin
      ev = e;
      wr(IEC_OFF_CTRL, (32'(e) << 4) | (32'(e) << 1));
      q(1, 5);
      q(-1, 2);
      rd(IEC_OFF_COUNT, 32'(cnt));
    end
    wr(IEC_OFF_CTRL, 32'h420);
    hi = 32'hffff;
    pre(32'h0);
    q(-1, 1);
    rd(IEC_OFF_COUNT, 32'hffff);
    wr(IEC_OFF_CTRL, 32'h20);
    wr(IEC_OFF_LOWER, 32'd10);
    wr(IEC_OFF_UPPER, 32'd20);
    lo = 10;
    hi = 20;
    pre(32'd30);
    rd(IEC_OFF_STATUS, 32'h4, 32'h4);
    pre(32'd15);
    q(1, 6);
    rd(IEC_OFF_STATUS, st());
    q(1, 4);
    rd(IEC_OFF_STATUS, st());
    q(-1, 5);
    rd(IEC_OFF_STATUS, st());
    q(-1, 5);
    rd(IEC_OFF_STATUS, st());
    wr(IEC_OFF_UPPER, 32'd12);
    rd(IEC_OFF_STATUS, 32'h4, 32'h4);
    wr(IEC_OFF_UPPER, 32'd20);
    wr(IEC_OFF_LOWER, 32'd25);
    rd(IEC_OFF_LOWER, 32'd10);
    wr(IEC_OFF_KEY, 32'h0);
    wr(IEC_OFF_LOWER, 32'd5);
    rd(IEC_OFF_LOWER, 32'd10);
    while (enc.ph != 0) q(1, 1);
    for (int m = 1; m < 6; m += 2) begin
      inv = m == 5;
      wr(IEC_OFF_CTRL, 32'(m) | 32'h20 | (m == 5 ? 32'h100 : 32'h0));
      pl(1'b0, 2);
      pl(1'b1, 1);
      rd(IEC_OFF_COUNT, 32'(cnt));
      rd(IEC_OFF_STATUS, st());
    end
    i_c_fault <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk({31'h0, led}, 32'h0);
    wr(IEC_OFF_CTRL, 32'h325);
    repeat (3) @(posedge i_mclk);
    chk({31'h0, led}, 32'h1);
    i_c_fault <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk({31'h0, led}, 32'h0);
    end_of_test();
  end

  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule
